// ### retd_pkg.sv
// Constants for the remap table entry target decoder.
// Assumes a 32-bit Avalon-MM register bus and one 50 MHz clock.
package retd_pkg;

   // Register byte offsets
   localparam logic [4:0] OFS_ENTRY_LO = 5'h00;
   localparam logic [4:0] OFS_ENTRY_HI = 5'h04;
   localparam logic [4:0] OFS_CTRL     = 5'h08;
   localparam logic [4:0] OFS_STATUS   = 5'h0C;
   localparam logic [4:0] OFS_DEST     = 5'h10;
   localparam logic [4:0] OFS_VECTOR   = 5'h14;

   // Control register fields
   localparam int CTRL_MODE_LSB  = 0;
   localparam int CTRL_MODE_MSB  = 2;
   localparam int CTRL_VALID_BIT = 8;
   localparam int CTRL_GO_BIT    = 31;

   // Status register fields
   localparam int STAT_DONE_BIT   = 0;
   localparam int STAT_POSTED_BIT = 1;
   localparam int STAT_RSVD_BIT   = 2;
   localparam int STAT_MODE_BIT   = 3;

   // Entry field positions (bits 63:0 of the table entry)
   localparam int TGT_MSB      = 63;
   localparam int TGT_LSB      = 32;
   localparam int LEG_HI_MSB   = 63;
   localparam int LEG_HI_LSB   = 48;
   localparam int LEG_CLU_MSB  = 47;
   localparam int LEG_CLU_LSB  = 44;
   localparam int LEG_ID_MSB   = 47;
   localparam int LEG_ID_LSB   = 40;
   localparam int LEG_LO_MSB   = 39;
   localparam int LEG_LO_LSB   = 32;
   localparam int RSVD_A_MSB   = 31;
   localparam int RSVD_A_LSB   = 24;
   localparam int VEC_MSB      = 23;
   localparam int VEC_LSB      = 16;
   localparam int KIND_BIT     = 15;
   localparam int RSVD_B_MSB   = 14;
   localparam int RSVD_B_LSB   = 12;
   localparam int SPARE_MSB    = 11;
   localparam int SPARE_LSB    = 8;

   // Reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [7:0]  RST_VEC  = 8'h00;

   // Platform interrupt modes
   typedef enum logic [2:0] {
      MODE_LEG_CLUSTER = 3'h0,
      MODE_LEG_FLAT    = 3'h1,
      MODE_LEG_PHYS    = 3'h2,
      MODE_EXT_CLUSTER = 3'h3,
      MODE_EXT_PHYS    = 3'h4
   } retd_mode_t;

endpackage : retd_pkg

// ### retd_dec_if.sv
// Carries one entry and its decoded fields between top and decoder.
// Assumes the decoder is purely combinational.
`timescale 1ns/1ps
interface retd_dec_if;
   logic [63:0] entry;
   logic [2:0]  mode;
   logic        present;
   logic [31:0] target_identifier;
   logic [7:0]  vector;
   logic        posted;
   logic        rsvd_err;
   logic        mode_err;

   modport ctl (output entry, mode, present,
                input  target_identifier, vector, posted, rsvd_err,
                       mode_err);
   modport dec (input  entry, mode, present,
                output target_identifier, vector, posted, rsvd_err,
                       mode_err);
endinterface : retd_dec_if

// ### retd_field_decode.sv
// Combinational field decoder for both halves of a 64-bit remap table entry.
// Assumes the caller registers every result.
`timescale 1ns/1ps
module retd_field_decode (
   // Entry in, fields out
   retd_dec_if.dec d
);

   logic [63:0] e;
   logic        legacy;
   logic        leg_rsvd;
   logic        com_rsvd;

   assign e = d.entry;

   always_comb begin
      d.target_identifier = 32'h0000_0000;
      d.mode_err          = 1'b0;
      legacy              = 1'b0;
      case (d.mode)
         3'(retd_pkg::MODE_LEG_CLUSTER): begin
            legacy = 1'b1;
            d.target_identifier = {24'h00_0000,
               e[retd_pkg::LEG_CLU_MSB:retd_pkg::LEG_CLU_LSB],
               e[retd_pkg::LEG_CLU_LSB-1:retd_pkg::LEG_ID_LSB]}; // [RULE_03]
         end
         3'(retd_pkg::MODE_LEG_FLAT), 3'(retd_pkg::MODE_LEG_PHYS): begin
            legacy = 1'b1;
            d.target_identifier = {24'h00_0000,
               e[retd_pkg::LEG_ID_MSB:retd_pkg::LEG_ID_LSB]}; // [RULE_04]
         end
         3'(retd_pkg::MODE_EXT_CLUSTER), 3'(retd_pkg::MODE_EXT_PHYS): begin
            d.target_identifier =
               e[retd_pkg::TGT_MSB:retd_pkg::TGT_LSB]; // [RULE_06]
         end
         default: begin
            d.mode_err = 1'b1;
         end
      endcase
   end // [RULE_02]

   // Spare bits 11:8 feed nothing below
   assign leg_rsvd = legacy &&
      ((|e[retd_pkg::LEG_HI_MSB:retd_pkg::LEG_HI_LSB]) ||
       (|e[retd_pkg::LEG_LO_MSB:retd_pkg::LEG_LO_LSB])); // [RULE_05]
   assign com_rsvd = (|e[retd_pkg::RSVD_A_MSB:retd_pkg::RSVD_A_LSB]) ||
      (|e[retd_pkg::RSVD_B_MSB:retd_pkg::RSVD_B_LSB]); // [RULE_07] [RULE_11]

   assign d.vector   = e[retd_pkg::VEC_MSB:retd_pkg::VEC_LSB]; // [RULE_08]
   assign d.posted   = e[retd_pkg::KIND_BIT]; // [RULE_09] [RULE_10]
   assign d.rsvd_err = d.present && !d.posted && (leg_rsvd || com_rsvd);

endmodule : retd_field_decode

// ### remap_entry_target_decode.sv
// Top of the remap table entry target decoder with Avalon-MM registers.
// Assumes a single clock and synchronous active-high reset.
//
// Chosen here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps

// Summary of operation
// RULE_01: Entry bits 63:32 are the target field, used only when present.
// RULE_02: Target field layout follows the selected platform interrupt mode.
// RULE_03: Legacy cluster: destination 7:4 from bits 47:44, 3:0 from 43:40.
// RULE_04: Legacy flat or physical: destination 7:0 taken from bits 47:40.
// RULE_05: Software zeroes bits 63:48 and 39:32 in every legacy format.
// RULE_06: Extended modes: destination 31:0 taken from bits 63:32.
// RULE_07: Software zeroes bits 31:24 and 14:12; checked only when present.
// RULE_08: Bits 23:16 are the vector, used only when present.
// RULE_09: Entry kind bit 15 zero means a remapped interrupt.
// RULE_10: Entry kind bit 15 one means posted; remapped layout not applied.
// RULE_11: Software spare bits 11:8 never affect decoding.
// RULE_12: Outputs register on the edge after a decode; reset clears them.
module remap_entry_target_decode (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // Avalon-MM slave
   input  wire logic [4:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   // Decoded results
   output logic      [31:0] target_identifier,
   output logic      [7:0]  vector,
   output logic             posted,
   output logic             out_valid,
   output logic             rsvd_err
);

   retd_dec_if dif ();

   logic [31:0] entry_lo;
   logic [31:0] entry_hi;
   logic [2:0]  mode;
   logic        present;
   logic        go;
   logic        mode_err;
   logic        acc;
   logic [31:0] next_readdata;

   assign dif.entry   = {entry_hi, entry_lo};
   assign dif.mode    = mode;
   assign dif.present = present;

   retd_field_decode u_dec (
      .d (dif.dec)
   );

   // Bus accepted at the edge where waitrequest is seen low
   assign acc = (read || write) && !waitrequest;

   always_ff @(posedge clk) begin
      if (srst) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= !((read || write) && waitrequest);
      end
   end

   always_comb begin
      next_readdata = retd_pkg::RST_WORD;
      case (address)
         retd_pkg::OFS_ENTRY_LO: next_readdata = entry_lo;
         retd_pkg::OFS_ENTRY_HI: next_readdata = entry_hi;
         retd_pkg::OFS_CTRL: begin
            next_readdata[retd_pkg::CTRL_MODE_MSB:retd_pkg::CTRL_MODE_LSB]
               = mode;
            next_readdata[retd_pkg::CTRL_VALID_BIT] = present;
         end
         retd_pkg::OFS_STATUS: begin
            next_readdata[retd_pkg::STAT_DONE_BIT]   = out_valid;
            next_readdata[retd_pkg::STAT_POSTED_BIT] = posted;
            next_readdata[retd_pkg::STAT_RSVD_BIT]   = rsvd_err;
            next_readdata[retd_pkg::STAT_MODE_BIT]   = mode_err;
         end
         retd_pkg::OFS_DEST:   next_readdata = target_identifier;
         retd_pkg::OFS_VECTOR: next_readdata = {24'h00_0000, vector};
         default:              next_readdata = retd_pkg::RST_WORD;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         readdata <= retd_pkg::RST_WORD;
      end else if (read && waitrequest) begin
         readdata <= next_readdata;
      end
   end

   // Register writes
   always_ff @(posedge clk) begin
      if (srst) begin
         entry_lo <= retd_pkg::RST_WORD;
         entry_hi <= retd_pkg::RST_WORD;
         mode     <= 3'h0;
         present  <= 1'b0;
      end else if (acc && write) begin
         case (address)
            retd_pkg::OFS_ENTRY_LO: entry_lo <= writedata;
            retd_pkg::OFS_ENTRY_HI: entry_hi <= writedata;
            retd_pkg::OFS_CTRL: begin
               mode <= writedata[retd_pkg::CTRL_MODE_MSB:
                                 retd_pkg::CTRL_MODE_LSB];
               present <= writedata[retd_pkg::CTRL_VALID_BIT];
            end
            default: begin
            end
         endcase
      end
   end

   // Decode launch one cycle after the control write
   always_ff @(posedge clk) begin
      if (srst) begin
         go <= 1'b0;
      end else begin
         go <= acc && write && (address == retd_pkg::OFS_CTRL) &&
               writedata[retd_pkg::CTRL_GO_BIT];
      end
   end

   // Result registers
   always_ff @(posedge clk) begin
      if (srst) begin
         target_identifier <= retd_pkg::RST_WORD;
         vector            <= retd_pkg::RST_VEC;
         posted            <= 1'b0;
         out_valid         <= 1'b0;
         rsvd_err          <= 1'b0;
         mode_err          <= 1'b0; // [RULE_12]
      end else if (go) begin
         out_valid <= present && !dif.mode_err; // [RULE_01]
         posted    <= present && dif.posted; // [RULE_10]
         rsvd_err  <= dif.rsvd_err; // [RULE_07]
         mode_err  <= dif.mode_err;
         if (present && !dif.posted && !dif.mode_err) begin
            target_identifier <= dif.target_identifier; // [RULE_01]
            vector            <= dif.vector; // [RULE_08] [RULE_09]
         end else begin
            target_identifier <= retd_pkg::RST_WORD;
            vector            <= retd_pkg::RST_VEC;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   // Reset and hold
   a_reset_clears: assert property ( // [RULE_12]
      $past(srst) |-> (target_identifier == 32'h0 && !out_valid && !posted))
      else $error("outputs not cleared by reset");
   a_no_go_hold: assert property ( // [RULE_12]
      !go |=> $stable(target_identifier) && $stable(vector) &&
      $stable(out_valid)) else $error("results moved without a decode");
   a_not_present: assert property ( // [RULE_01]
      go && !present |=> !out_valid && target_identifier == 32'h0
      && vector == 8'h00) else $error("absent entry decoded");

   // Target layout per mode
   a_leg_cluster: assert property ( // [RULE_03]
      go && present && !entry_lo[15] && mode == 3'h0 |=>
      target_identifier == {24'h0, $past(entry_hi[15:12]),
      $past(entry_hi[11:8])}) else $error("cluster target wrong");
   a_leg_flat: assert property ( // [RULE_04]
      go && present && !entry_lo[15] && (mode == 3'h1 || mode == 3'h2) |=>
      target_identifier == {24'h0, $past(entry_hi[15:8])})
      else $error("flat target wrong");
   a_ext_target: assert property ( // [RULE_06]
      go && present && !entry_lo[15] && (mode == 3'h3 || mode == 3'h4) |=>
      target_identifier == $past(entry_hi))
      else $error("ext target wrong");
   a_mode_layout: assert property ( // [RULE_02]
      go && mode > 3'h4 |=> !out_valid)
      else $error("bad mode accepted");

   // Vector and entry kind
   a_vector_out: assert property ( // [RULE_08]
      go && present && !entry_lo[15] && mode <= 3'h4 |=>
      vector == $past(entry_lo[23:16])) else $error("vector wrong");
   a_kind_remap: assert property ( // [RULE_09]
      go && present && !entry_lo[15] && mode <= 3'h4 |=>
      !posted && out_valid) else $error("remapped entry not taken");
   a_posted_kind: assert property ( // [RULE_09]
      go && present |=> posted == $past(entry_lo[15]))
      else $error("entry kind wrong");
   a_posted_zero: assert property ( // [RULE_10]
      go && present && entry_lo[15] && mode <= 3'h4 |=>
      target_identifier == 32'h0 && vector == 8'h00 && out_valid)
      else $error("posted entry took remap layout");

   // Reserved and spare bits
   a_rsvd_check: assert property ( // [RULE_07]
      go && present && !entry_lo[15] &&
      ((|entry_lo[31:24]) || (|entry_lo[14:12])) |=> rsvd_err)
      else $error("reserved bits not flagged");
   a_leg_rsvd: assert property ( // [RULE_05]
      go && present && !entry_lo[15] && mode <= 3'h2 &&
      ((|entry_hi[31:16]) || (|entry_hi[7:0])) |=> rsvd_err)
      else $error("legacy reserved not flagged");
   a_spare_ignored: assert property ( // [RULE_11]
      go && present && !entry_lo[15] && !(|entry_lo[31:24]) &&
      !(|entry_lo[14:12]) && (mode >= 3'h3 ||
      (!(|entry_hi[31:16]) && !(|entry_hi[7:0]))) |=> !rsvd_err)
      else $error("spare bits influenced decode");

   // Bus handshake
   a_bus_answer: assert property (
      (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
      else $error("bus answer timing wrong");
   a_bus_idle: assert property (
      !(read || write) |=> waitrequest) else $error("answer without request");

   c_decode_ext: cover property (go && present && mode == 3'h3);
   c_decode_posted: cover property (go && present && entry_lo[15]);
   c_decode_rsvd: cover property (go ##1 rsvd_err);
   c_decode_cluster: cover property (go && present && mode == 3'h0);
   c_bus_write: cover property (write && !waitrequest);

endmodule : remap_entry_target_decode

// ### retd_entry_model.sv
// Table entries as software leaves them in memory.
// Assumes the bench picks an entry by index and copies it to the block.
`timescale 1ns/1ps
module retd_entry_model (
   // Entry selection
   input  wire logic [2:0]  idx,
   // Selected entry, bits 63:0
   output logic      [63:0] entry
);
   always_comb begin
      case (idx)
         // Entry 0 legacy layout, entry 1 extended target; bits 31:24 and 14:12 zero
         3'h0:    entry = 64'h0000_5A00_0042_0000;
         3'h1:    entry = 64'h1234_5678_0091_0000;
         // Kind bit set
         3'h2:    entry = 64'h0000_3C00_0077_8000;
         // Spare bits written by software
         3'h3:    entry = 64'h0000_5A00_0042_0F00;
         // Faulty entries, commanded by the bench only
         3'h4:    entry = 64'h0001_5A00_0042_0000;
         3'h5:    entry = 64'h0000_5A00_0042_7000;
         default: entry = 64'h0000_0000_0000_0000;
      endcase
   end
endmodule : retd_entry_model

// ### test_remap_entry_target_decode.sv
// Self-checking bench for the remap table entry target decoder.
// Assumes 50 MHz clock, synchronous reset, one wait state per bus access.
`timescale 1ns/1ps
module test_remap_entry_target_decode;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic [4:0]  address = 5'h00;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata, target_identifier;
   logic        waitrequest, posted, out_valid, rsvd_err;
   logic [7:0]  vector;
   logic [2:0]  ent_idx = 3'h0;
   logic [63:0] ent;
   int          err_total = 0;
   int          compares = 0;

   localparam logic [2:0] m_lc = retd_pkg::MODE_LEG_CLUSTER;
   localparam logic [2:0] m_lf = retd_pkg::MODE_LEG_FLAT;
   localparam logic [2:0] m_lp = retd_pkg::MODE_LEG_PHYS;
   localparam logic [2:0] m_ec = retd_pkg::MODE_EXT_CLUSTER;
   localparam logic [2:0] m_ep = retd_pkg::MODE_EXT_PHYS;

   always #10 clk = ~clk;

   remap_entry_target_decode dut_u (.clk(clk), .srst(srst),
      .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .target_identifier(target_identifier),
      .vector(vector), .posted(posted), .out_valid(out_valid),
      .rsvd_err(rsvd_err));
   retd_entry_model ent_u (.idx(ent_idx), .entry(ent));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic end_of_test;
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test

   // One Avalon access, held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      address <= a;
      writedata <= wd;
      write <= wr;
      read <= ~wr;
      @(posedge clk);
      while (waitrequest) @(posedge clk);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      // Idle edge before the next request
      @(posedge clk);
   endtask : bus

   task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] d;
      bus(1'b0, a, 32'h0, d);
      chk(d, exp);
   endtask : rd_chk

   task automatic dec(input logic [2:0] i, input logic [2:0] m,
                      input logic p, input logic [31:0] et,
                      input logic [7:0] ev, input logic [3:0] ef);
      logic [31:0] d;
      ent_idx <= i;
      @(posedge clk);
      bus(1'b1, retd_pkg::OFS_ENTRY_LO, ent[31:0], d);
      bus(1'b1, retd_pkg::OFS_ENTRY_HI, ent[63:32], d);
      bus(1'b1, retd_pkg::OFS_CTRL, {23'h0, p, 5'h00, m} | 32'h8000_0000, d);
      repeat (2) @(posedge clk);
      chk(target_identifier, et);
      chk({24'h0, vector}, {24'h0, ev});
      chk({29'h0, rsvd_err, posted, out_valid}, {29'h0, ef[2:0]});
      rd_chk(retd_pkg::OFS_STATUS, {28'h0, ef});
      rd_chk(retd_pkg::OFS_DEST, et);
      rd_chk(retd_pkg::OFS_VECTOR, {24'h0, ev});
   endtask : dec

   task automatic reg_access;
      logic [31:0] d;
      rd_chk(retd_pkg::OFS_ENTRY_HI, 32'h0000_5A00);
      rd_chk(retd_pkg::OFS_CTRL, 32'h0000_0100);
      bus(1'b1, retd_pkg::OFS_STATUS, 32'hFFFF_FFFF, d);
      rd_chk(retd_pkg::OFS_STATUS, 32'h0000_0001);
      bus(1'b1, 5'h18, 32'hFFFF_FFFF, d);
      rd_chk(5'h18, 32'h0);
      // Control write without go: mode latches, results stay
      bus(1'b1, retd_pkg::OFS_CTRL, 32'h0000_0003, d);
      rd_chk(retd_pkg::OFS_CTRL, 32'h0000_0003);
      rd_chk(retd_pkg::OFS_DEST, 32'h0000_005A);
      rd_chk(retd_pkg::OFS_STATUS, 32'h0000_0001);
   endtask : reg_access

   task automatic legacy_targets;
      dec(3'h0, m_lc, 1'b1, 32'h5A, 8'h42, 4'h1);
      dec(3'h0, m_lf, 1'b1, 32'h5A, 8'h42, 4'h1);
      dec(3'h0, m_lp, 1'b1, 32'h5A, 8'h42, 4'h1);
      dec(3'h3, m_lc, 1'b1, 32'h5A, 8'h42, 4'h1);
   endtask : legacy_targets

   task automatic extended_targets;
      dec(3'h1, m_ec, 1'b1, 32'h1234_5678, 8'h91, 4'h1);
      dec(3'h1, m_ep, 1'b1, 32'h1234_5678, 8'h91, 4'h1);
      dec(3'h1, m_lf, 1'b1, 32'h56, 8'h91, 4'h5);
      dec(3'h0, 3'h5, 1'b1, 32'h0, 8'h00, 4'h8);
   endtask : extended_targets

   task automatic kind_and_absence;
      dec(3'h2, m_lp, 1'b1, 32'h0, 8'h00, 4'h3);
      dec(3'h0, m_lc, 1'b1, 32'h5A, 8'h42, 4'h1);
      dec(3'h0, m_lc, 1'b0, 32'h0, 8'h00, 4'h0);
   endtask : kind_and_absence

   task automatic reserved_bits;
      dec(3'h4, m_lc, 1'b1, 32'h5A, 8'h42, 4'h5);
      dec(3'h5, m_ep, 1'b1, 32'h5A00, 8'h42, 4'h5);
      dec(3'h5, m_ep, 1'b0, 32'h0, 8'h00, 4'h0);
      dec(3'h0, m_lc, 1'b1, 32'h5A, 8'h42, 4'h1);
   endtask : reserved_bits

   initial begin
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk(target_identifier, 32'h0);
      chk({24'h0, vector}, 32'h0);
      chk({31'h0, waitrequest}, 32'h1);
      chk({29'h0, posted, out_valid, rsvd_err}, 32'h0);
      legacy_targets();
      extended_targets();
      kind_and_absence();
      reserved_bits();
      reg_access();
      end_of_test();
   end

   // Hang guard, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      end_of_test();
   end
endmodule : test_remap_entry_target_decode
